// *** hdl/sfm_pkg.sv ***
// Constants and types for the supply, CAN fault and chip mode supervisor.
// Assumes a single 125 MHz clock and an asynchronous active-low reset.
package sfm_pkg;
    // ****************************************************************
    // Clock and times
    // ****************************************************************
    localparam int CLK_MHZ = 125;
    localparam int DOM_TIMEOUT_US = 2000;
    localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * CLK_MHZ;
    localparam int RESET_HOLD_US = 1000;
    localparam int RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ;
    localparam int RESET_GIVEUP_US = 100000;
    localparam int RESET_GIVEUP_CYC = RESET_GIVEUP_US * CLK_MHZ;
    localparam int CONFIG_WAIT_US = 75000;
    localparam int CONFIG_WAIT_CYC = CONFIG_WAIT_US * CLK_MHZ;
    localparam int FILTER_CYC = 1000;
    localparam int RECOVER_CYC = 4000;
    localparam int WAKE_CYC = 500;
    localparam int CNT_W = 24;

    // ****************************************************************
    // Modes and field layout
    // ****************************************************************
    typedef enum logic [2:0] {
        CHIP_RESET = 3'h0,
        CHIP_WAIT_CFG = 3'h1,
        CHIP_NORMAL = 3'h2,
        CHIP_STANDBY = 3'h3,
        CHIP_SLEEP = 3'h4,
        CHIP_EMERGENCY = 3'h5
    } sfm_chip_e;

    typedef enum logic [1:0] {
        XM_FULL = 2'h0,
        XM_LISTEN = 2'h1,
        XM_TERM_LOGIC = 2'h2,
        XM_BUS_LOW_POWER = 2'h3
    } sfm_xcvr_e;

    localparam int NUM_FAULTS = 8;
    localparam int SUP_FAIL_BIT = 0;
    localparam int SUP_HIGH_BIT = 1;
    localparam int SUP_PERIPH_UV_BIT = 2;
    localparam logic [7:0] HIGH_SIDE_FAULTS = 8'h84;
    localparam logic [7:0] LOW_SIDE_FAULTS = 8'h68;
    localparam logic [7:0] STANDBY_FAULTS = 8'hcc;
    localparam logic [7:0] FAULTS_DEFAULT = 8'h00;
    localparam logic [2:0] SUP_DEFAULT = 3'h0;
    localparam logic [1:0] XMODE_DEFAULT = 2'h3;
endpackage : sfm_pkg

// *** hdl/sfm_supervisor.sv ***
// Supply flags, CAN transceiver fault handling and chip mode sequencing.
// Assumes comparator and SPI-decoded inputs synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
module sfm_supervisor #(
    parameter int RESET_HOLD = sfm_pkg::RESET_HOLD_CYC,     // Reset mode minimum
    parameter int RESET_GIVEUP = sfm_pkg::RESET_GIVEUP_CYC, // Regulator give-up time
    parameter int CONFIG_WAIT = sfm_pkg::CONFIG_WAIT_CYC,   // Configuration time-out
    parameter int DOM_TIMEOUT = sfm_pkg::DOM_TIMEOUT_CYC,   // Transmit dominant limit
    parameter int FILTER = sfm_pkg::FILTER_CYC,             // Fault filter time
    parameter int RECOVER = sfm_pkg::RECOVER_CYC,           // Fault recovery time
    parameter int WAKE = sfm_pkg::WAKE_CYC,                 // Wake qualification
    parameter bit SLEEP_ON_GIVEUP = 1'b1                    // Variant: sleep or stay in reset
) (
    input wire logic clock,                  // System clock
    input wire logic rst_n,                  // Async reset, active low
    input wire logic batLow,                 // Battery below 4V comparator
    input wire logic batOver,                // Battery above 20V comparator
    input wire logic periphUv,               // Peripheral regulator undervoltage
    input wire logic mcuRegLow,              // Mcu regulator below reset threshold
    input wire logic overTemp,               // Junction over-temperature
    input wire logic wdFault,                // Incorrect watchdog trigger
    input wire logic [7:0] faultRaw,         // Fault comparators, bit i = fault i+1
    input wire logic busDomHigh,             // High wire dominant
    input wire logic busDomLow,              // Low wire dominant
    input wire logic busDomDiff,             // Differential dominant
    input wire logic txDom,                  // Transmit input dominant
    input wire logic spiAny,                 // Any SPI frame received, pulse
    input wire logic spiWdCfg,               // Watchdog timing word written, pulse
    input wire logic spiXcvrWr,              // Transceiver control write, pulse
    input wire logic [1:0] spiXcvrMode,      // Mode data written
    input wire logic spiModeWr,              // Chip mode write, pulse
    input wire sfm_pkg::sfm_chip_e spiChipMode, // Requested chip mode
    input wire logic spiRdFault,             // Fault status read, pulse
    input wire logic spiRdSupply,            // Supply status read, pulse
    input wire logic spiRdWake,              // Wake status read, pulse
    input wire logic [10:0] irqMask,         // 1 enables: supply[1:0], faults, wake
    output logic irqOut_n,                   // Interrupt, active low
    output logic [2:0] supplyStatus,         // Supply status register
    output logic [7:0] faultStatus,          // Error status high and low
    output logic wakeStatus,                 // Wake event status
    output sfm_pkg::sfm_chip_e chipMode,     // Chip mode
    output sfm_pkg::sfm_xcvr_e xcvrMode,     // Effective transceiver mode
    output logic wdRunning,                  // Watchdog started
    output logic mcuRegOn,                   // Mcu regulator enable
    output logic periphRegOn,                // Peripheral regulator enable
    output logic batSwitchOn,                // Battery switch enable
    output logic highDrvEn,                  // High wire driver enable
    output logic lowDrvEn,                   // Low wire driver enable
    output logic rxEn,                       // Receiver enable
    output logic rxOut,                      // Receive output, 1 = dominant
    output logic singleWireHigh,             // Receive single wire on high
    output logic highTermGnd,                // High termination ground switch closed
    output logic lowTermLogic,               // Low termination logic switch closed
    output logic lowTermBat                  // Low termination battery switch closed
);
    import sfm_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    sfm_chip_e chip_r, chip_nxt;
    sfm_xcvr_e sel_r;
    logic [CNT_W-1:0] modeCnt_r;
    logic [CNT_W-1:0] domCnt_r;
    logic [CNT_W-1:0] wakeCnt_r;
    logic domTrip_r, wake_r, wdOn_r;
    logic [7:0] faultAct_r, flag_r;
    logic [2:0] sup_r;
    logic [NUM_FAULTS-1:0] detEn;

    // Fault detection enable per mode
    wire detFull = (xcvrMode == XM_FULL) || (xcvrMode == XM_LISTEN);
    wire inStandby = (xcvrMode == XM_BUS_LOW_POWER) || (xcvrMode == XM_TERM_LOGIC);
    assign detEn = detFull ? 8'hff : (inStandby ? STANDBY_FAULTS : 8'h00);

    // ****************************************************************
    // Fault filters
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FAULTS; gi++) begin : gFault
            logic [CNT_W-1:0] cnt_r;
            wire on = faultRaw[gi] && detEn[gi];
            // Filtered set, timed recovery once comparator quiet and bus not differential dominant
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_r <= '0;
                    faultAct_r[gi] <= 1'b0;
                end else if (!faultAct_r[gi]) begin
                    cnt_r <= on ? cnt_r + 1'b1 : '0;
                    if (on && cnt_r >= CNT_W'(FILTER - 1)) begin
                        faultAct_r[gi] <= 1'b1;
                        cnt_r <= '0;
                    end
                end else begin
                    cnt_r <= (on || busDomDiff) ? '0 : cnt_r + 1'b1;
                    if (!on && !busDomDiff && cnt_r >= CNT_W'(RECOVER - 1)) begin
                        faultAct_r[gi] <= 1'b0;
                        cnt_r <= '0;
                    end
                end
            end
            // Sticky flag outside reset mode, where it follows the fault; set wins over read clear
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    flag_r[gi] <= 1'b0;
                end else if (faultAct_r[gi] || chip_r == CHIP_RESET) begin
                    flag_r[gi] <= faultAct_r[gi];
                end else if (spiRdFault) begin
                    flag_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Reaction decode: which wire is lost
    wire highLost = |(faultAct_r & HIGH_SIDE_FAULTS);
    wire lowLost = |(faultAct_r & LOW_SIDE_FAULTS);

    // ****************************************************************
    // Supply flags
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sup_r <= SUP_DEFAULT;
        end else begin
            sup_r[SUP_FAIL_BIT] <= batLow || (sup_r[SUP_FAIL_BIT] && !spiRdSupply);
            sup_r[SUP_HIGH_BIT] <= batOver || (sup_r[SUP_HIGH_BIT] && !spiRdSupply);
            sup_r[SUP_PERIPH_UV_BIT] <= periphUv || (sup_r[SUP_PERIPH_UV_BIT] && !spiRdSupply);
        end
    end

    // ****************************************************************
    // Transmit dominant time-out
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            domCnt_r <= '0;
            domTrip_r <= 1'b0;
        end else if (!txDom) begin
            domCnt_r <= '0;
            domTrip_r <= 1'b0;
        end else if (domCnt_r >= CNT_W'(DOM_TIMEOUT)) begin
            domTrip_r <= 1'b1;
        end else begin
            domCnt_r <= domCnt_r + 1'b1;
        end
    end

    // ****************************************************************
    // Bus wake-up
    // ****************************************************************
    wire wakeIn = (busDomHigh || busDomLow) && inStandby;
    wire wakeHit = wakeIn && wakeCnt_r == CNT_W'(WAKE - 1);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wakeCnt_r <= '0;
            wake_r <= 1'b0;
        end else begin
            wakeCnt_r <= wakeIn ? (wakeHit ? wakeCnt_r : wakeCnt_r + 1'b1) : '0;
            wake_r <= wakeHit || (wake_r && !spiRdWake);
        end
    end

    // ****************************************************************
    // Chip mode sequencer
    // ****************************************************************
    wire holdDone = modeCnt_r >= CNT_W'(RESET_HOLD - 1);
    wire giveUp = modeCnt_r >= CNT_W'(RESET_GIVEUP - 1);
    wire cfgLate = modeCnt_r >= CNT_W'(CONFIG_WAIT - 1);
    wire modeOk = spiModeWr && chip_r != CHIP_EMERGENCY;
    always_comb begin
        chip_nxt = chip_r;
        unique case (chip_r)
            CHIP_RESET: begin
                if (holdDone && !mcuRegLow) begin
                    chip_nxt = CHIP_WAIT_CFG;
                end else if (giveUp && SLEEP_ON_GIVEUP) begin
                    chip_nxt = CHIP_SLEEP;
                end
            end
            CHIP_WAIT_CFG: begin
                if (spiModeWr && spiChipMode == CHIP_EMERGENCY) begin
                    chip_nxt = CHIP_EMERGENCY;
                end else if (spiWdCfg) begin
                    chip_nxt = CHIP_NORMAL;
                end else if (cfgLate && !wdOn_r) begin
                    chip_nxt = CHIP_SLEEP;
                end
            end
            CHIP_NORMAL, CHIP_STANDBY: begin
                if (wdFault || mcuRegLow) begin
                    chip_nxt = CHIP_RESET;
                end else if (modeOk && spiChipMode != CHIP_RESET) begin
                    chip_nxt = spiChipMode;
                end
            end
            CHIP_SLEEP: begin
                if (wakeHit) begin
                    chip_nxt = CHIP_WAIT_CFG;
                end else if (modeOk && spiChipMode == CHIP_EMERGENCY) begin
                    chip_nxt = CHIP_EMERGENCY;
                end
            end
            CHIP_EMERGENCY: chip_nxt = CHIP_EMERGENCY;
            default: chip_nxt = CHIP_RESET;
        endcase
    end

    // Mode register and time-in-mode counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chip_r <= CHIP_WAIT_CFG;
            modeCnt_r <= '0;
            wdOn_r <= 1'b0;
        end else begin
            chip_r <= chip_nxt;
            modeCnt_r <= (chip_nxt != chip_r) ? '0 : modeCnt_r + {{(CNT_W-1){1'b0}}, !giveUp};
            if (chip_nxt == CHIP_WAIT_CFG && chip_r != CHIP_WAIT_CFG) begin
                wdOn_r <= 1'b0;
            end else if (chip_r == CHIP_WAIT_CFG && spiWdCfg) begin
                wdOn_r <= 1'b1;
            end else if (chip_r == CHIP_WAIT_CFG && spiAny && !wdOn_r) begin
                wdOn_r <= 1'b0;
            end
        end
    end

    // Selected transceiver mode; dropped to standby on supply loss
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= XM_BUS_LOW_POWER;
        end else if (chip_r != CHIP_NORMAL || periphUv) begin
            sel_r <= XM_BUS_LOW_POWER;
        end else if (spiXcvrWr && wdOn_r) begin
            sel_r <= sfm_xcvr_e'(spiXcvrMode);
        end
    end

    // ****************************************************************
    // Effective outputs
    // ****************************************************************
    wire normal = chip_r == CHIP_NORMAL;
    wire sb = !normal || periphUv;
    wire sfm_xcvr_e effMode = sb ? XM_BUS_LOW_POWER : sel_r;
    wire full = effMode == XM_FULL;
    wire listen = effMode == XM_LISTEN;
    wire txOk = full && !domTrip_r && !overTemp;
    wire oneWire = lowLost ? busDomHigh : (highLost ? busDomLow : busDomDiff);
    wire rxNext = (full || listen) && (oneWire || (listen && txDom));
    wire mcuNext = chip_r != CHIP_SLEEP && chip_r != CHIP_EMERGENCY;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqOut_n <= 1'b1;
            supplyStatus <= SUP_DEFAULT;
            faultStatus <= FAULTS_DEFAULT;
            wakeStatus <= 1'b0;
            chipMode <= CHIP_WAIT_CFG;
            xcvrMode <= XM_BUS_LOW_POWER;
            wdRunning <= 1'b0;
            mcuRegOn <= 1'b1;
            periphRegOn <= 1'b0;
            batSwitchOn <= 1'b0;
            highDrvEn <= 1'b0;
            lowDrvEn <= 1'b0;
            rxEn <= 1'b0;
            rxOut <= 1'b0;
            singleWireHigh <= 1'b0;
            highTermGnd <= 1'b0;
            lowTermLogic <= 1'b0;
            lowTermBat <= 1'b1;
        end else begin
            irqOut_n <= !(|({wake_r, flag_r, sup_r[1:0]} & irqMask));
            supplyStatus <= sup_r;
            faultStatus <= flag_r;
            wakeStatus <= wake_r;
            chipMode <= chip_r;
            xcvrMode <= effMode;
            wdRunning <= wdOn_r;
            mcuRegOn <= mcuNext;
            periphRegOn <= normal;
            batSwitchOn <= 1'b0;
            highDrvEn <= txOk && !highLost;
            lowDrvEn <= txOk && !lowLost;
            rxEn <= full || listen;
            rxOut <= rxNext;
            singleWireHigh <= lowLost;
            highTermGnd <= !highLost;
            lowTermLogic <= !lowLost && !sb;
            lowTermBat <= !lowLost && sb;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_standby_drivers: assert property (@(posedge clock) disable iff (!rst_n)
        !$past(normal) |=> !highDrvEn && !lowDrvEn) else $error("drivers on outside normal");
    chk_uv_standby: assert property (@(posedge clock) disable iff (!rst_n)
        periphUv |=> xcvrMode == XM_BUS_LOW_POWER) else $error("uv did not force standby");
    chk_temp_tx: assert property (@(posedge clock) disable iff (!rst_n)
        overTemp |=> !highDrvEn && !lowDrvEn) else $error("driver on in overtemp");
    chk_low_lost: assert property (@(posedge clock) disable iff (!rst_n)
        lowLost |=> !lowDrvEn && !lowTermLogic && !lowTermBat) else $error("low side not cut");
    chk_high_lost: assert property (@(posedge clock) disable iff (!rst_n)
        highLost |=> !highDrvEn && !highTermGnd) else $error("high side not cut");
    chk_supply_flag: assert property (@(posedge clock) disable iff (!rst_n)
        batLow |=> ##1 supplyStatus[SUP_FAIL_BIT]) else $error("battery fail flag missing");
    chk_wd_first: assert property (@(posedge clock) disable iff (!rst_n)
        chip_r == CHIP_WAIT_CFG && spiWdCfg && !(spiModeWr && spiChipMode == CHIP_EMERGENCY)
        |=> chip_r == CHIP_NORMAL && wdOn_r) else $error("timing word not taken");
    chk_irq_mask: assert property (@(posedge clock) disable iff (!rst_n)
        irqMask == 11'h000 |=> irqOut_n) else $error("masked interrupt asserted");
    chk_wake_sleep: assert property (@(posedge clock) disable iff (!rst_n)
        chip_r == CHIP_SLEEP && wakeHit |=> chip_r == CHIP_WAIT_CFG && wake_r)
        else $error("wake from sleep lost");
endmodule : sfm_supervisor
`default_nettype wire

// *** bench/sfm_bus_model.sv ***
// Partner model of the CAN bus wires that face the transceiver.
// Assumes driver enables from the design and remote traffic from the bench.
`timescale 1ns/100ps
`default_nettype none
module sfm_bus_model (
    input wire logic txDom,     // Local transmit dominant
    input wire logic drvOn,     // Any local driver enabled
    input wire logic remoteDom, // Remote node drives dominant
    output logic busDomHigh,    // High wire dominant
    output logic busDomLow,     // Low wire dominant
    output logic busDomDiff     // Differential dominant
);
    // Wired-or of the local driver and the remote node
    assign busDomHigh = remoteDom | (txDom & drvOn);
    assign busDomLow = busDomHigh;
    assign busDomDiff = busDomHigh;
endmodule : sfm_bus_model
`default_nettype wire

// *** bench/sfm_supervisor_tb.sv ***
// Self-checking bench for the supply, CAN fault and chip mode supervisor.
// Assumes shortened timing parameters and a 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module sfm_supervisor_tb;
    import sfm_pkg::*;
    localparam int HOLD = 20, CFGW = 40, DOM = 30, FLT = 4, RCV = 8, WK = 4, GIVE = 60;
    logic clock = 0, rst_n = 0, batLow = 0, batOver = 0, periphUv = 0, overTemp = 0;
    logic wdFault = 0, txDom = 0, remoteDom = 0, spiAny = 0, spiWdCfg = 0, spiXcvrWr = 0;
    logic spiRdFault = 0, spiRdSupply = 0, mcuRegLow = 0;
    logic [1:0] spiXcvrMode = 0;
    logic [7:0] faultRaw = 0;
    logic [10:0] irqMask = 11'h7ff;
    logic irqOut_n, wakeStatus, wdRunning, mcuRegOn, periphRegOn, batSwitchOn, highDrvEn;
    logic lowDrvEn, rxEn, rxOut, singleWireHigh, highTermGnd, lowTermLogic, lowTermBat;
    logic busDomHigh, busDomLow, busDomDiff;
    logic [2:0] supplyStatus;
    logic [7:0] faultStatus;
    sfm_chip_e chipMode;
    sfm_xcvr_e xcvrMode;
    int errors = 0, total_checks = 0, n;
    // Rows: mode, transmit level, then {rxEn, highDrvEn, lowDrvEn, rxOut}
    logic [7:0] rows [4] = '{8'h1f, 8'h39, 8'h40, 8'h60};

    sfm_supervisor #(.RESET_HOLD(HOLD), .RESET_GIVEUP(GIVE), .CONFIG_WAIT(CFGW),
        .DOM_TIMEOUT(DOM), .FILTER(FLT), .RECOVER(RCV), .WAKE(WK)) u_dut (
        .clock, .rst_n, .batLow, .batOver, .periphUv, .mcuRegLow, .overTemp, .wdFault,
        .faultRaw, .busDomHigh, .busDomLow, .busDomDiff, .txDom, .spiAny, .spiWdCfg,
        .spiXcvrWr, .spiXcvrMode, .spiModeWr(1'b0), .spiChipMode(CHIP_NORMAL), .spiRdFault,
        .spiRdSupply, .spiRdWake(1'b0), .irqMask, .irqOut_n, .supplyStatus, .faultStatus,
        .wakeStatus, .chipMode, .xcvrMode, .wdRunning, .mcuRegOn, .periphRegOn, .batSwitchOn,
        .highDrvEn, .lowDrvEn, .rxEn, .rxOut, .singleWireHigh, .highTermGnd, .lowTermLogic,
        .lowTermBat);
    sfm_bus_model u_bus (.txDom, .drvOn(highDrvEn | lowDrvEn), .remoteDom, .busDomHigh,
        .busDomLow, .busDomDiff);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial forever #4 clock = ~clock;
    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask : cyc
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic waitMode(input sfm_chip_e m, input int bound);
        n = 0;
        while (chipMode !== m && n < bound) begin
            cyc(1);
            n++;
        end
        if (n >= bound) begin
            errors++;
            conclude();
        end
    endtask : waitMode
    task automatic wrMode(input logic [1:0] m);
        spiXcvrMode = m;
        spiXcvrWr = 1;
        cyc(1);
        spiXcvrWr = 0;
        cyc(3);
    endtask : wrMode
    task automatic fault(input logic [7:0] f, input logic [14:0] exp);
        faultRaw = f;
        cyc(FLT + 3);
        chk("fault", {faultStatus, highDrvEn, highTermGnd, lowDrvEn, lowTermLogic, lowTermBat,
            singleWireHigh, irqOut_n}, exp);
        faultRaw = 0;
        cyc(RCV + 4);
        chk("sticky", faultStatus, f);
        spiRdFault = 1;
        cyc(1);
        spiRdFault = 0;
        cyc(3);
        chk("cleared", {faultStatus, highDrvEn, lowDrvEn, irqOut_n}, 11'h007);
    endtask : fault

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial begin
        cyc(12);
        rst_n = 1;
        cyc(1);
        chk("chip", chipMode, CHIP_WAIT_CFG);
        chk("dflt", {mcuRegOn, periphRegOn, batSwitchOn, lowTermBat, wdRunning, irqOut_n,
            xcvrMode}, 8'h97);
        wrMode(2'h0);
        chk("refused", xcvrMode, XM_BUS_LOW_POWER);
        spiWdCfg = 1;
        cyc(1);
        spiWdCfg = 0;
        cyc(2);
        chk("cfg", {chipMode, wdRunning, periphRegOn}, {CHIP_NORMAL, 2'b11});
        foreach (rows[i]) begin
            txDom = rows[i][4];
            wrMode(rows[i][6:5]);
            chk("mode", {rxEn, highDrvEn, lowDrvEn, rxOut}, rows[i][3:0]);
            if (rows[i][6:5] != 2'h2) chk("xmode", xcvrMode, rows[i][6:5]);
            txDom = 0;
            cyc(1);
        end
        wrMode(2'h0);
        fault(8'h04, 15'h0218);
        fault(8'h08, 15'h0462);
        fault(8'h01, 15'h00f8);
        irqMask = 11'h7fe;
        batLow = 1;
        cyc(3);
        chk("batmask", {supplyStatus, irqOut_n}, 4'h3);
        irqMask = 11'h7ff;
        cyc(3);
        chk("batirq", irqOut_n, 1'b0);
        irqMask = 11'h000;
        cyc(3);
        chk("irqoff", irqOut_n, 1'b1);
        irqMask = 11'h7ff;
        batLow = 0;
        batOver = 1;
        cyc(3);
        chk("battery_high_flag", {supplyStatus, periphRegOn}, 4'h7);
        batOver = 0;
        spiRdSupply = 1;
        cyc(1);
        spiRdSupply = 0;
        cyc(3);
        chk("supclr", {supplyStatus, irqOut_n}, 4'h1);
        overTemp = 1;
        cyc(3);
        chk("otemp", {highDrvEn, lowDrvEn, rxEn, xcvrMode}, 5'h04);
        overTemp = 0;
        txDom = 1;
        cyc(DOM - 6);
        chk("txearly", {highDrvEn, lowDrvEn}, 2'h3);
        cyc(10);
        chk("txstuck", {highDrvEn, lowDrvEn, rxEn}, 3'h1);
        txDom = 0;
        periphUv = 1;
        cyc(3);
        chk("uv", xcvrMode, XM_BUS_LOW_POWER);
        periphUv = 0;
        cyc(4);
        chk("uvstay", {xcvrMode, supplyStatus[SUP_PERIPH_UV_BIT]}, 3'h7);
        wdFault = 1;
        cyc(1);
        wdFault = 0;
        waitMode(CHIP_RESET, 5);
        waitMode(CHIP_WAIT_CFG, HOLD + 10);
        chk("hold", n >= HOLD - 2, 1'b1);
        spiAny = 1;
        cyc(1);
        spiAny = 0;
        waitMode(CHIP_SLEEP, CFGW + 10);
        chk("cfgwait", n >= CFGW - 8, 1'b1);
        remoteDom = 1;
        waitMode(CHIP_WAIT_CFG, WK + 10);
        remoteDom = 0;
        cyc(3);
        chk("wake", {wakeStatus, xcvrMode}, 3'h7);
        // Regulator failing in reset: no exit at hold time, sleep at give-up
        spiWdCfg = 1;
        cyc(1);
        spiWdCfg = 0;
        waitMode(CHIP_NORMAL, 5);
        mcuRegLow = 1;
        waitMode(CHIP_RESET, 5);
        waitMode(CHIP_SLEEP, GIVE + 10);
        chk("giveup", n >= GIVE - 12, 1'b1);
        // Bus standby keeps only faults 3, 4, 7 and 8 detected
        faultRaw = 8'h19;
        cyc(FLT + 3);
        chk("sbfault", {faultStatus, lowTermBat, highTermGnd}, 10'h021);
        faultRaw = 0;
        conclude();
    end
endmodule : sfm_supervisor_tb
`default_nettype wire
